// ### rtl/esp_pkg.sv
// Constants and types for the encoder SPI position slave.
// Assumes a 20 MHz system clock; all times are converted here.
package esp_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned MEAS_MIN_NS = 90000;
    localparam int unsigned AUTO_MIN_NS = 135000;
    localparam int unsigned GAP_NS = 10000;
    localparam int unsigned MEAS_CYC =
        (MEAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned AUTO_CYC =
        (AUTO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GAP_CYC =
        (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    typedef logic [CNT_W-1:0] esp_cnt_t;
    localparam esp_cnt_t MEAS_LAST = esp_cnt_t'(MEAS_CYC - 1);
    localparam esp_cnt_t AUTO_LAST = esp_cnt_t'(AUTO_CYC - 1);
    localparam esp_cnt_t GAP_LAST = esp_cnt_t'(GAP_CYC - 1);
    localparam esp_cnt_t CNT_ONE = 12'h001;

    // ==========================================================
    // Frame layout
    localparam int FRAME_W = 48;
    localparam int PAD_W = 15;
    localparam int POS_W = 22;
    localparam int CRC_W = 7;
    localparam int CRC_IN_W = 32;
    localparam int CRC_PAD_W = 6;
    localparam int BIT_ZERO_DEF = 32;
    localparam int BIT_VALID = 31;
    localparam int BIT_SYNCED = 30;
    localparam int POS_LSB = 8;
    localparam int BIT_SENT = 7;
    localparam logic [CRC_W-1:0] CRC_POLY = 7'h5B;
    typedef logic [5:0] esp_bit_cnt_t;
    localparam esp_bit_cnt_t FRAME_BITS = 6'h30;
    localparam esp_bit_cnt_t PAD_BITS = 6'h0F;
    localparam esp_bit_cnt_t BIT_ONE = 6'h01;

    // ==========================================================
    // Register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    typedef logic [ADDR_W-1:0] esp_addr_t;
    localparam esp_addr_t REG_CTRL = 8'h00;
    localparam esp_addr_t REG_SENSOR = 8'h04;
    localparam esp_addr_t REG_STATUS = 8'h08;
    localparam esp_addr_t REG_RESULT = 8'h0C;
    localparam int CTRL_ZERO_BIT = 0;
    localparam int CTRL_RES_LSB = 8;
    localparam int RES_W = 5;
    localparam logic [RES_W-1:0] RES_MAX = 5'h16;
    localparam logic CTRL_ZERO_RST = 1'b1;
    localparam int SENS_VALID_BIT = 31;
    localparam int ST_BUSY = 0;
    localparam int ST_ACTIVE = 1;
    localparam int ST_SENT = 2;
    localparam int ST_SYNCED = 3;
    localparam int ST_CNT_LSB = 8;

    typedef enum logic {ESP_IDLE, ESP_MEAS} esp_meas_st_t;

endpackage

// ### rtl/esp_meas_if.sv
// Link between the serial front end and the measurement timebase.
// Both ends run on the same system clock.
`timescale 1ns/10ps
interface esp_meas_if;
    logic frame_start;
    logic busy;
    logic done;
    logic synced;

    modport engine (
        input frame_start,
        output busy,
        output done,
        output synced
    );
    modport front (
        output frame_start,
        input busy,
        input done,
        input synced
    );
endinterface

// ### rtl/esp_meas.sv
// Measurement timebase: frame and timeout triggers, fixed duration.
// Assumes frame_start is a one-cycle pulse on the same clock.
`timescale 1ns/10ps
module esp_meas (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    esp_meas_if.engine mif
);
    import esp_pkg::*;

    esp_meas_st_t state_reg;
    esp_meas_st_t state_next;
    esp_cnt_t meas_cnt_reg;
    esp_cnt_t meas_cnt_next;
    esp_cnt_t since_reg;
    esp_cnt_t since_next;
    logic synced_reg;
    logic synced_next;
    logic done_reg;
    logic done_next;
    logic auto_hit;
    logic trig;

    // ==========================================================
    // Trigger and duration
    always_comb begin
        state_next = state_reg;
        meas_cnt_next = meas_cnt_reg;
        synced_next = synced_reg;
        done_next = 1'b0;
        since_next = since_reg + CNT_ONE;
        auto_hit = (since_reg == AUTO_LAST);
        trig = 1'b0;
        case (state_reg)
            ESP_IDLE: begin
                // Frame beats timeout when both land together
                if (mif.frame_start || auto_hit) begin
                    trig = 1'b1;
                    state_next = ESP_MEAS;
                    meas_cnt_next = '0;
                    synced_next = mif.frame_start;
                    since_next = '0;
                end
            end
            ESP_MEAS: begin
                // Frames arriving now are not retriggers
                meas_cnt_next = meas_cnt_reg + CNT_ONE;
                if (meas_cnt_reg == MEAS_LAST) begin
                    state_next = ESP_IDLE;
                    done_next = 1'b1;
                end
            end
            default: begin
                state_next = ESP_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_reg <= ESP_IDLE;
            meas_cnt_reg <= '0;
            since_reg <= '0;
            synced_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            meas_cnt_reg <= meas_cnt_next;
            since_reg <= since_next;
            synced_reg <= synced_next;
            done_reg <= done_next;
        end
    end

    assign mif.busy = (state_reg == ESP_MEAS);
    assign mif.done = done_reg;
    assign mif.synced = synced_reg;

    // ==========================================================
    // Checks
    esp_cnt_t age_reg;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            age_reg <= '0;
        end else if (trig) begin
            age_reg <= '0;
        end else begin
            age_reg <= age_reg + CNT_ONE;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    AST_MEAS_TIME: assert property (
        $rose(done_reg) |-> age_reg == esp_cnt_t'(MEAS_CYC))
        else $error("measurement length wrong");
    AST_AUTO_TRIG: assert property (
        since_reg <= AUTO_LAST)
        else $error("timeout trigger missed");
    AST_NO_RETRIG: assert property (
        mif.busy && mif.frame_start && !done_next
        |=> meas_cnt_reg == $past(meas_cnt_reg) + CNT_ONE)
        else $error("busy measurement restarted");
    AST_FRAME_TRIG: assert property (
        mif.frame_start && !mif.busy |=> mif.busy && synced_reg)
        else $error("frame did not trigger");

    COV_AUTO: cover property (auto_hit && state_reg == ESP_IDLE);
    COV_BUSY_FRAME: cover property (mif.busy && mif.frame_start);

endmodule // esp_meas

// ### rtl/esp_top.sv
// Encoder SPI slave: 48-bit position frame out, APB control.
// Assumes the SPI clock is asynchronous and at most 2.5 MHz here.
`timescale 1ns/10ps
module esp_top (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_sclk,
    output logic o_sdo,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [esp_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [esp_pkg::DATA_W-1:0] i_pwdata,
    output logic [esp_pkg::DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr
);
    import esp_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [POS_W-1:0] pos_mask(
        input logic [RES_W-1:0] res
    );
        logic [POS_W-1:0] m;
        m = '1;
        if (res < RES_MAX) begin
            m = m >> (RES_MAX - res);
        end
        return m;
    endfunction

    function automatic logic [CRC_W-1:0] crc7(
        input logic [CRC_IN_W-1:0] d
    );
        logic [CRC_W-1:0] c;
        logic fb;
        c = '0;
        fb = 1'b0;
        for (int i = CRC_IN_W - 1; i >= 0; i--) begin
            fb = d[i] ^ c[CRC_W-1];
            c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
        end
        return c;
    endfunction

    esp_meas_if mif ();

    esp_meas u_meas (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .mif(mif.engine)
    );

    // ==========================================================
    // State declarations
    logic sck_meta_reg;
    logic sck_meta_next;
    logic sck_sync_reg;
    logic sck_sync_next;
    logic sck_prev_reg;
    logic sck_prev_next;
    esp_cnt_t idle_cnt_reg;
    esp_cnt_t idle_cnt_next;
    esp_bit_cnt_t bit_cnt_reg;
    esp_bit_cnt_t bit_cnt_next;
    logic [FRAME_W-1:0] shift_reg;
    logic [FRAME_W-1:0] shift_next;
    logic frame_start_reg;
    logic frame_start_next;
    logic sent_reg;
    logic sent_next;
    logic [POS_W-1:0] res_pos_reg;
    logic [POS_W-1:0] res_pos_next;
    logic res_valid_reg;
    logic res_valid_next;
    logic res_sync_reg;
    logic res_sync_next;
    logic zero_def_reg;
    logic zero_def_next;
    logic [RES_W-1:0] res_bits_reg;
    logic [RES_W-1:0] res_bits_next;
    logic [POS_W-1:0] sens_pos_reg;
    logic [POS_W-1:0] sens_pos_next;
    logic sens_valid_reg;
    logic sens_valid_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;

    logic sck_rise;
    logic sck_fall;
    logic frame_reset;
    logic frame_begin;
    logic [CRC_IN_W-1:0] crc_in;
    logic [FRAME_W-1:0] load_word;
    logic [DATA_W-1:0] rd_word;
    logic addr_hit;
    logic apb_access;
    logic apb_done;

    // ==========================================================
    // Frame content from the latest completed result
    always_comb begin
        crc_in = {{CRC_PAD_W{1'b0}}, zero_def_reg, res_valid_reg,
            res_sync_reg, res_pos_reg, sent_reg};
        load_word = {{PAD_W{1'b0}},
            crc_in[BIT_ZERO_DEF-BIT_SENT:0], crc7(crc_in)};
    end

    // ==========================================================
    // Serial clock, framing and shifter
    always_comb begin
        sck_meta_next = i_sclk;
        sck_sync_next = sck_meta_reg;
        sck_prev_next = sck_sync_reg;
        sck_rise = sck_sync_reg && !sck_prev_reg;
        sck_fall = !sck_sync_reg && sck_prev_reg;
        // Gap only counts while the clock rests high
        if (!sck_sync_reg || sck_rise) begin
            idle_cnt_next = '0;
        end else if (idle_cnt_reg == GAP_LAST) begin
            idle_cnt_next = idle_cnt_reg;
        end else begin
            idle_cnt_next = idle_cnt_reg + CNT_ONE;
        end
        frame_reset = (idle_cnt_reg == GAP_LAST);
        // The fall that ends a long gap must open a frame, not be lost
        frame_begin = sck_fall && (frame_reset
            || bit_cnt_reg == '0 || bit_cnt_reg == FRAME_BITS);
        frame_start_next = frame_begin;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        if (frame_begin) begin
            bit_cnt_next = BIT_ONE;
        end else if (frame_reset) begin
            bit_cnt_next = '0;
        end else if (sck_fall) begin
            bit_cnt_next = bit_cnt_reg + BIT_ONE;
        end
        // Idle shifter tracks the newest result until the frame
        if (bit_cnt_reg == '0 || frame_reset) begin
            shift_next = load_word;
        end else if (sck_rise) begin
            if (bit_cnt_reg == FRAME_BITS) begin
                shift_next = load_word;
            end else begin
                shift_next = {shift_reg[FRAME_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sck_meta_reg <= 1'b1;
            sck_sync_reg <= 1'b1;
            sck_prev_reg <= 1'b1;
            idle_cnt_reg <= '0;
            bit_cnt_reg <= '0;
            shift_reg <= '0;
            frame_start_reg <= 1'b0;
        end else begin
            sck_meta_reg <= sck_meta_next;
            sck_sync_reg <= sck_sync_next;
            sck_prev_reg <= sck_prev_next;
            idle_cnt_reg <= idle_cnt_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            frame_start_reg <= frame_start_next;
        end
    end

    assign mif.frame_start = frame_start_reg;
    assign o_sdo = shift_reg[FRAME_W-1];

    // ==========================================================
    // Result latch and stale flag
    always_comb begin
        res_pos_next = res_pos_reg;
        res_valid_next = res_valid_reg;
        res_sync_next = res_sync_reg;
        sent_next = sent_reg;
        if (mif.done) begin
            res_pos_next = sens_pos_reg & pos_mask(res_bits_reg);
            res_valid_next = sens_valid_reg;
            res_sync_next = mif.synced;
            // Fresh data was not in the frame now starting
            sent_next = 1'b0;
        end else if (frame_start_reg) begin
            sent_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            res_pos_reg <= '0;
            res_valid_reg <= 1'b0;
            res_sync_reg <= 1'b0;
            sent_reg <= 1'b0;
        end else begin
            res_pos_reg <= res_pos_next;
            res_valid_reg <= res_valid_next;
            res_sync_reg <= res_sync_next;
            sent_reg <= sent_next;
        end
    end

    // ==========================================================
    // APB slave, one wait state
    always_comb begin
        rd_word = '0;
        addr_hit = 1'b1;
        case (i_paddr)
            REG_CTRL: begin
                rd_word[CTRL_ZERO_BIT] = zero_def_reg;
                rd_word[CTRL_RES_LSB +: RES_W] = res_bits_reg;
            end
            REG_SENSOR: begin
                rd_word[POS_W-1:0] = sens_pos_reg;
                rd_word[SENS_VALID_BIT] = sens_valid_reg;
            end
            REG_STATUS: begin
                rd_word[ST_BUSY] = mif.busy;
                rd_word[ST_ACTIVE] = (bit_cnt_reg != '0);
                rd_word[ST_SENT] = sent_reg;
                rd_word[ST_SYNCED] = res_sync_reg;
                rd_word[ST_CNT_LSB +: 6] = bit_cnt_reg;
            end
            REG_RESULT: begin
                rd_word = load_word[DATA_W-1:0];
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        apb_access = i_psel && i_penable;
        apb_done = apb_access && pready_reg;
        pready_next = apb_access && !pready_reg;
        pslverr_next = 1'b0;
        prdata_next = '0;
        if (apb_access && !pready_reg) begin
            pslverr_next = !addr_hit;
            prdata_next = i_pwrite ? '0 : rd_word;
        end
        zero_def_next = zero_def_reg;
        res_bits_next = res_bits_reg;
        sens_pos_next = sens_pos_reg;
        sens_valid_next = sens_valid_reg;
        if (apb_done && i_pwrite) begin
            if (i_paddr == REG_CTRL) begin
                zero_def_next = i_pwdata[CTRL_ZERO_BIT];
                res_bits_next = i_pwdata[CTRL_RES_LSB +: RES_W];
            end
            if (i_paddr == REG_SENSOR) begin
                sens_pos_next = i_pwdata[POS_W-1:0];
                sens_valid_next = i_pwdata[SENS_VALID_BIT];
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
            zero_def_reg <= CTRL_ZERO_RST;
            res_bits_reg <= RES_MAX;
            sens_pos_reg <= '0;
            sens_valid_reg <= 1'b0;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
            zero_def_reg <= zero_def_next;
            res_bits_reg <= res_bits_next;
            sens_pos_reg <= sens_pos_next;
            sens_valid_reg <= sens_valid_next;
        end
    end

    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_prdata = prdata_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    AST_PAD_ZERO: assert property (
        bit_cnt_reg < PAD_BITS |-> !o_sdo)
        else $error("padding bit not zero");
    AST_EDGE_ONLY: assert property (
        $changed(shift_reg[FRAME_W-2:0]) && bit_cnt_reg != '0
        |-> $past(sck_rise))
        else $error("data moved off the rising edge");
    AST_FRAME_LEN: assert property (
        bit_cnt_reg <= FRAME_BITS)
        else $error("frame longer than 48 bits");
    AST_MSB_FIRST: assert property (
        sck_rise && bit_cnt_reg != '0 && bit_cnt_reg != FRAME_BITS
        |=> shift_reg == {$past(shift_reg[FRAME_W-2:0]), 1'b0})
        else $error("shift order wrong");
    AST_CRC: assert property (
        load_word[CRC_W-1:0] == crc7({{CRC_PAD_W{1'b0}},
            load_word[BIT_ZERO_DEF:BIT_SENT]}))
        else $error("checksum field wrong");
    AST_POS_MASK: assert property (
        mif.done |=> (res_pos_reg & ~pos_mask(res_bits_reg)) == '0)
        else $error("unused position bits set");
    AST_IDLE_RESET: assert property (
        frame_reset |=> bit_cnt_reg == ($past(sck_fall) ? BIT_ONE : '0))
        else $error("framing not reset after gap");
    AST_SENT: assert property (
        frame_start_reg && !mif.done |=> sent_reg)
        else $error("stale flag not set");
    AST_LATCH: assert property (
        mif.done |=> res_valid_reg == $past(sens_valid_reg)
        && res_sync_reg == $past(mif.synced))
        else $error("result not latched");
    AST_ZERO_BIT: assert property (
        load_word[BIT_ZERO_DEF] == zero_def_reg
        && load_word[BIT_VALID] == res_valid_reg
        && load_word[BIT_SYNCED] == res_sync_reg)
        else $error("flag bits misplaced");

    COV_FULL_FRAME: cover property (sck_fall && bit_cnt_reg == 6'h2F);
    COV_BACK_TO_BACK: cover property (
        sck_fall && bit_cnt_reg == FRAME_BITS);
    COV_GAP_RESET: cover property (
        frame_reset && bit_cnt_reg != '0);

endmodule // esp_top

// ### test/esp_spi_master.sv
// Far-side SPI master model: idle-high clock, 400 ns period.
// Assumes the 50 ns system clock; a frame starts on an i_go pulse.
`timescale 1ns/10ps
module esp_spi_master (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic [5:0] i_nbits,
    input wire logic i_sdo,
    output logic o_sclk,
    output logic o_busy,
    output logic [47:0] o_rx
);
    // ==========================================================
    // Clock maker and sampler
    logic [2:0] ph_reg;
    logic [5:0] n_reg;
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_sclk <= 1'b1;
            o_busy <= 1'b0;
            ph_reg <= 3'h0;
            n_reg <= 6'h00;
            o_rx <= 48'h0;
        end else if (!o_busy) begin
            o_busy <= i_go;
            ph_reg <= 3'h0;
            n_reg <= 6'h00;
        end else begin
            // Eight system clocks a bit, no byte gaps
            ph_reg <= ph_reg + 3'h1;
            if (ph_reg == 3'h0) o_sclk <= 1'b0;
            // Sampled one clock after the fall: the bit stands until rise
            if (ph_reg == 3'h1) o_rx <= {o_rx[46:0], i_sdo};
            if (ph_reg == 3'h4) o_sclk <= 1'b1;
            if (ph_reg == 3'h7) begin
                n_reg <= n_reg + 6'h01;
                if (n_reg + 6'h01 == i_nbits) o_busy <= 1'b0;
            end
        end
    end
endmodule // esp_spi_master

// ### test/esp_top_tb_top.sv
// Testbench of the encoder SPI slave: APB set-up, frames, timing.
// Assumes esp_spi_master as the far side and a 20 MHz clock.
`timescale 1ns/10ps
module esp_top_tb_top;
    import esp_pkg::*;
    // ==========================================================
    // Signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic [5:0] nbits = 6'h30;
    logic sclk, sdo, mbusy, pready, pslverr;
    logic [47:0] rx;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    esp_addr_t paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] seed = 32'h00000049;
    int err_total = 0;
    int tests_run = 0;
    int cyc_n = 0;
    int t0 = 0;

    initial forever #25 clk = ~clk;
    always @(posedge clk) cyc_n <= cyc_n + 1;

    esp_top u_esp_top (.i_clk_sys(clk), .i_rst(rst), .i_sclk(sclk),
        .o_sdo(sdo), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr));
    esp_spi_master u_esp_spi_master (.i_clk_sys(clk), .i_rst(rst),
        .i_go(go), .i_nbits(nbits), .i_sdo(sdo), .o_sclk(sclk),
        .o_busy(mbusy), .o_rx(rx));

    // ==========================================================
    // Helpers
    task automatic report_and_stop;
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic bail;
        err_total++;
        report_and_stop();
    endtask

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        for (int i = 0; i < 32; i++) begin
            s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        end
        return s;
    endfunction

    function automatic logic [47:0] exp_frame(input logic z, v, s,
            input logic [21:0] a, input logic [4:0] r, input logic sent);
        logic [47:0] f;
        logic [31:0] w;
        logic [6:0] c;
        f = 48'h0;
        f[32] = z;
        f[31] = v;
        f[30] = s;
        f[29:8] = (r >= 5'h16) ? a : a & ((22'h000001 << r) - 22'h000001);
        f[7] = sent;
        w = {6'h00, f[32:7]};
        c = 7'h00;
        for (int i = 31; i >= 0; i--) begin
            c = {c[5:0], 1'b0} ^ ((c[6] ^ w[i]) ? 7'h5B : 7'h00);
        end
        f[6:0] = c;
        return f;
    endfunction

    task automatic apb(input logic wr, input esp_addr_t a,
            input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int k;
        k = 0;
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
        if (k >= 20) bail();
    endtask

    task automatic wait_to(input int t);
        while (cyc_n < t) @(posedge clk);
    endtask

    task automatic frame(input logic [5:0] n);
        int k;
        k = 0;
        t0 = cyc_n;
        nbits <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(posedge clk);
            k++;
        end while (mbusy !== 1'b0 && k < 500);
        if (k >= 500) bail();
    endtask

    task automatic busy_at(input int t, input logic b);
        logic [31:0] d;
        logic e;
        wait_to(t);
        apb(1'b0, REG_STATUS, 32'h00000000, d, e);
        check({47'h0, d[ST_BUSY]}, {47'h0, b});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] d;
        logic e, z, v, have;
        logic [47:0] ex, prev, msk, pmsk;
        logic [4:0] res;
        logic [21:0] ang;
        have = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, REG_CTRL, 32'h00000000, d, e);
        check({16'h0, d}, {16'h0, 32'(RES_MAX) << CTRL_RES_LSB
            | 32'(CTRL_ZERO_RST)});
        apb(1'b0, 8'h10, 32'h00000000, d, e);
        check({15'h0, e, d}, {15'h0, 1'b1, 32'h00000000});
        wait_to(cyc_n + 220);
        // Corner resolutions first, then random ones
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            res = (i == 0) ? 5'h16 : (i == 1) ? 5'h00 :
                (i == 2) ? 5'h1F : 5'(seed % 23);
            v = (i != 3);
            z = seed[7];
            ang = seed[29:8];
            apb(1'b1, REG_SENSOR, {v, 9'h000, ang}, d, e);
            frame(6'h30);
            if (have) check(rx & pmsk, prev & pmsk);
            apb(1'b1, REG_CTRL, {19'h0, res, 7'h00, z}, d, e);
            wait_to(t0 + 1910);
            frame(6'h30);
            msk = v ? 48'hFFFFFFFFFFFF : 48'hFFFF80000000;
            ex = exp_frame(z, v, 1'b1, ang, res, 1'b0);
            check(rx & msk, ex & msk);
            prev = exp_frame(z, v, 1'b1, ang, res, 1'b1);
            pmsk = msk;
            have = 1'b1;
        end
        busy_at(t0 + 1795, 1'b1);
        busy_at(t0 + 1905, 1'b0);
        busy_at(t0 + 2690, 1'b0);
        busy_at(t0 + 2915, 1'b1);
        wait_to(t0 + 4600);
        frame(6'h30);
        check(rx, exp_frame(z, v, 1'b0, ang, res, 1'b0));
        // Broken frame, then a long idle to regain alignment
        frame(6'h14);
        wait_to(cyc_n + 220);
        frame(6'h30);
        check(rx, exp_frame(z, v, 1'b0, ang, res, 1'b1));
        report_and_stop();
    end
endmodule // esp_top_tb_top
